// file: eeprom_prog_defs.vh
`ifndef EEPROM_PROG_DEFS_VH
`define EEPROM_PROG_DEFS_VH

// opcode field
`define OPC_EXT      2'h0
`define OPC_WRITE    2'h1
`define OPC_READ     2'h2
`define OPC_ERASE    2'h3
// extended commands, top two address bits under opcode 00
`define EXT_DISABLE  2'h0
`define EXT_FILL     2'h1
`define EXT_CLEAR    2'h2
`define EXT_ENABLE   2'h3
// field widths per organisation
`define ADDR_W16     4'hA
`define ADDR_W8      4'hB
`define DATA_W16     5'h10
`define DATA_W8      5'h08
// self-timed programming time, in microseconds
`define PROG_TIME_US 5000
`define CLK_MHZ      40
`define PROG_CYCLES  (`PROG_TIME_US * `CLK_MHZ)
// reset values
`define WEN_RESET    1'b0

`endif

// file: pin_sync.v
`timescale 1ns/1ps
// two-stage synchroniser for pins from outside the clock domain
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             i_core_clk,
  input  wire             i_srst,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // pin_sync

// file: prog_checker.sv
`timescale 1ns/1ps
module prog_checker #(
  parameter PROG_CYCLES = 200000
) (
  input wire i_core_clk,
  input wire i_srst,
  input wire i_chip_select,
  input wire o_data_out,
  input wire o_data_out_en,
  input wire o_prog_write,
  input wire o_prog_all,
  input wire o_read_req,
  input wire o_write_enabled,
  input wire o_busy
);
  // busy cycles seen so far; cleared while idle
  reg [31:0] busy_cnt_q;
  always @(posedge i_core_clk)
    if (i_srst || !o_busy) busy_cnt_q <= 32'h0;
    else busy_cnt_q <= busy_cnt_q + 32'h1;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  ////////////////////////////////////////////////////////////////
  a_boot_disabled: assert property ($fell(i_srst) |-> !o_write_enabled)
    else $error("write enabled after reset");
  a_release_deselect: assert property (!i_chip_select [*4] |-> !o_data_out_en)
    else $error("data out driven while deselected");
  a_busy_length: assert property ($fell(o_busy) |-> busy_cnt_q == PROG_CYCLES)
    else $error("busy period has wrong length");
  a_prog_sets_busy: assert property (o_prog_write |=> o_busy)
    else $error("programming start without busy");
  a_prog_needs_enable: assert property (o_prog_write |-> o_write_enabled)
    else $error("programming while disabled");
  a_prog_while_busy: assert property (o_prog_write |-> !$past(o_busy))
    else $error("command accepted while busy");
  a_enable_at_deselect: assert property ($changed(o_write_enabled) |-> !$past(i_chip_select, 2))
    else $error("enable state changed while selected");
  a_busy_shows_zero: assert property (o_busy && $past(o_busy, 2) && o_data_out_en |-> !o_data_out)
    else $error("ready shown while busy");
  a_ready_after_busy: assert property ($fell(o_busy) ##2 o_data_out_en |-> o_data_out)
    else $error("ready not shown after busy");
  c_fill: cover property (o_prog_write && o_prog_all);
  c_read: cover property (o_read_req);
  c_ready: cover property ($fell(o_busy) ##2 (o_data_out_en && o_data_out));
endmodule // prog_checker
bind serial_eeprom_program_control prog_checker #(.PROG_CYCLES(PROG_CYCLES)) prog_checker_inst (
  .i_core_clk, .i_srst, .i_chip_select, .o_data_out, .o_data_out_en,
  .o_prog_write, .o_prog_all, .o_read_req, .o_write_enabled, .o_busy);

// file: prog_timer.v
`timescale 1ns/1ps
// self-timed programming counter; start loads, busy stays high for CYCLES cycles
module prog_timer #(
  parameter CYCLES = 200000
) (
  input  wire i_core_clk,
  input  wire i_srst,
  input  wire i_start,
  output wire o_busy,
  output wire o_done
);
  reg  [31:0] cnt_q;
  reg         done_q;

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      cnt_q  <= 32'h0;
      done_q <= 1'b0;
    end else if (i_start && cnt_q == 32'h0) begin
      cnt_q  <= CYCLES;
      done_q <= 1'b0;
    end else if (cnt_q != 32'h0) begin
      cnt_q  <= cnt_q - 32'h1;
      done_q <= (cnt_q == 32'h1);
    end else begin
      done_q <= 1'b0;
    end
  end

  assign o_busy = (cnt_q != 32'h0);
  assign o_done = done_q;
endmodule // prog_timer

// file: serial_eeprom_program_control.v
`timescale 1ns/1ps
`include "eeprom_prog_defs.vh"
module serial_eeprom_program_control #(
  parameter PROG_CYCLES = `PROG_CYCLES
) (
  input  wire        i_core_clk,
  input  wire        i_srst,
  input  wire        i_chip_select,
  input  wire        i_serial_clock_in,
  input  wire        i_serial_data_in,
  input  wire        i_word_width_select,
  output reg         o_data_out,
  output reg         o_data_out_en,
  output reg         o_prog_write,
  output reg         o_prog_all,
  output reg  [10:0] o_prog_addr,
  output reg  [15:0] o_prog_data,
  output reg         o_read_req,
  output reg  [10:0] o_read_addr,
  output wire        o_write_enabled,
  output wire        o_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and clock edge detect

  wire [3:0] pins_s;
  reg        sk_prev_q;
  reg        cs_prev_q;

  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_async    ({i_word_width_select, i_serial_data_in, i_serial_clock_in, i_chip_select}),
    .o_sync     (pins_s)
  );

  wire cs_s    = pins_s[0];
  wire sk_s    = pins_s[1];
  wire di_s    = pins_s[2];
  wire org16_s = pins_s[3];
  wire sk_rise = sk_s & ~sk_prev_q & cs_s;
  wire cs_fall = cs_prev_q & ~cs_s;

  ////////////////////////////////////////////////////////////////////////////
  // command shifter

  localparam ST_IDLE = 2'h0;
  localparam ST_OPC  = 2'h1;
  localparam ST_ADDR = 2'h2;
  localparam ST_DATA = 2'h3;

  reg  [1:0]  state_q;
  reg  [4:0]  cnt_q;
  reg  [1:0]  opc_q;
  reg  [10:0] addr_q;
  reg  [15:0] data_q;
  reg         wen_q;
  reg  [1:0]  pend_q;   // control command waiting for chip select fall
  reg         ready_q;  // ready indication latched after programming
  reg         hold_q;   // ignore rest of a command arriving while busy

  wire        timer_busy;
  wire        timer_done;
  reg         start_prog;

  wire [4:0]  addr_len = org16_s ? {1'b0, `ADDR_W16} : {1'b0, `ADDR_W8};
  wire [4:0]  data_len = org16_s ? `DATA_W16 : `DATA_W8;
  wire [10:0] addr_nx  = {addr_q[9:0], di_s};
  wire [15:0] data_nx  = {data_q[14:0], di_s};
  // top two address bits select the extended command
  wire [1:0]  ext_code = org16_s ? addr_nx[9:8] : addr_nx[10:9];
  wire [1:0]  ext_held = org16_s ? addr_q[9:8] : addr_q[10:9];
  wire [15:0] data_fit = org16_s ? data_nx : {8'h00, data_nx[7:0]};

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      sk_prev_q    <= 1'b0;
      cs_prev_q    <= 1'b0;
      state_q      <= ST_IDLE;
      cnt_q        <= 5'h00;
      opc_q        <= 2'h0;
      addr_q       <= 11'h000;
      data_q       <= 16'h0000;
      wen_q        <= `WEN_RESET;
      pend_q       <= 2'h0;
      ready_q      <= 1'b0;
      hold_q       <= 1'b0;
      o_prog_write <= 1'b0;
      o_prog_all   <= 1'b0;
      o_prog_addr  <= 11'h000;
      o_prog_data  <= 16'h0000;
      o_read_req   <= 1'b0;
      o_read_addr  <= 11'h000;
    end else begin
      sk_prev_q    <= sk_s;
      cs_prev_q    <= cs_s;
      o_read_req   <= 1'b0;
      if (cs_fall) begin
        // deselect resets decoding; only complete control commands act
        state_q <= ST_IDLE;
        hold_q  <= 1'b0;
        pend_q  <= 2'h0;
        if (pend_q == 2'h1) begin
          wen_q <= 1'b1;
        end else if (pend_q == 2'h2) begin
          wen_q <= 1'b0;
        end
      end else if (sk_rise) begin
        case (state_q)
          ST_IDLE: begin
            if (di_s) begin
              ready_q <= 1'b0;
              hold_q  <= timer_busy;
              state_q <= ST_OPC;
              cnt_q   <= 5'h00;
              // stale bits of the last command must not reach bit 10 in 16-bit mode
              addr_q  <= 11'h000;
            end
          end
          ST_OPC: begin
            opc_q <= {opc_q[0], di_s};
            cnt_q <= cnt_q + 5'h01;
            if (cnt_q == 5'h01) begin
              state_q <= ST_ADDR;
              cnt_q   <= 5'h00;
            end
          end
          ST_ADDR: begin
            addr_q <= addr_nx;
            cnt_q  <= cnt_q + 5'h01;
            if (cnt_q == addr_len - 5'h01) begin
              cnt_q   <= 5'h00;
              state_q <= ST_IDLE;
              if (hold_q) begin
                state_q <= ST_IDLE;
              end else if (opc_q == `OPC_READ) begin
                o_read_req  <= 1'b1;
                o_read_addr <= addr_nx;
              end else if (opc_q == `OPC_WRITE) begin
                state_q <= ST_DATA;
              end else if (opc_q == `OPC_ERASE) begin
                o_prog_addr <= addr_nx;
                o_prog_data <= org16_s ? 16'hFFFF : 16'h00FF;
                o_prog_all  <= 1'b0;
              end else if (ext_code == `EXT_FILL) begin
                state_q <= ST_DATA;
              end else if (ext_code == `EXT_CLEAR) begin
                o_prog_data <= org16_s ? 16'hFFFF : 16'h00FF;
                o_prog_all  <= 1'b1;
              end else if (ext_code == `EXT_ENABLE) begin
                pend_q <= 2'h1;
              end else begin
                pend_q <= 2'h2;
              end
            end
          end
          ST_DATA: begin
            data_q <= data_nx;
            cnt_q  <= cnt_q + 5'h01;
            if (cnt_q == data_len - 5'h01) begin
              state_q     <= ST_IDLE;
              o_prog_addr <= addr_q;
              o_prog_data <= data_fit;
              o_prog_all  <= (opc_q == `OPC_EXT) && (ext_held == `EXT_FILL);
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
      // set wins over a start bit clearing in the same cycle
      if (timer_done) begin
        ready_q <= 1'b1;
      end
      o_prog_write <= start_prog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // programming launch on the final command bit

  always @* begin
    start_prog = 1'b0;
    if (!cs_fall && sk_rise && wen_q && !hold_q && !timer_busy) begin
      if (state_q == ST_DATA && cnt_q == data_len - 5'h01) begin
        start_prog = 1'b1;
      end else if (state_q == ST_ADDR && cnt_q == addr_len - 5'h01) begin
        if (opc_q == `OPC_ERASE) begin
          start_prog = 1'b1;
        end else if (opc_q == `OPC_EXT && ext_code == `EXT_CLEAR) begin
          start_prog = 1'b1;
        end
      end
    end
  end

  prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_start    (start_prog),
    .o_busy     (timer_busy),
    .o_done     (timer_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // data-out status: driven only while selected, no clock needed

  always @(posedge i_core_clk) begin
    if (i_srst) begin
      o_data_out    <= 1'b0;
      o_data_out_en <= 1'b0;
    end else begin
      o_data_out    <= ready_q;
      // registered from synced select so polling needs no serial clock; a start bit ends it
      o_data_out_en <= cs_s && (timer_busy || ready_q) && state_q == ST_IDLE;
    end
  end

  assign o_write_enabled = wen_q;
  assign o_busy          = timer_busy;

endmodule // serial_eeprom_program_control

// file: serial_master_model.sv
`timescale 1ns/1ps
module serial_master_model (
  input  wire i_core_clk,
  output reg  o_chip_select,
  output reg  o_serial_clock,
  output reg  o_serial_data
);
  initial begin
    o_chip_select = 1'b0;
    o_serial_clock = 1'b0;
    o_serial_data = 1'b0;
  end
  // 4 settling cycles cover deselect time and the synchroniser delay
  task select(input logic v);
    @(negedge i_core_clk);
    o_chip_select = v;
    repeat (4) @(negedge i_core_clk);
  endtask
  // clock runs only inside frames, offset from the core clock phase
  task shift(input logic [31:0] b, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      o_serial_data = b[k];
      repeat (4) @(negedge i_core_clk);
      o_serial_clock = 1'b1;
      repeat (4) @(negedge i_core_clk);
      o_serial_clock = 1'b0;
    end
    o_serial_data = ~o_serial_data; // hold over: no stale level
  endtask
endmodule // serial_master_model

// file: testbench.sv
`timescale 1ns/1ps
`include "eeprom_prog_defs.vh"
module testbench;
  localparam int PC = 50;
  reg clk = 1'b0;
  reg srst = 1'b1;
  reg w16 = 1'b1;
  wire cs, sk, di, dout, dout_en, pw, pall, rreq, wen, busy;
  wire [10:0] paddr, raddr;
  wire [15:0] pdata;
  wire [27:0] prog_got = {pall, pall ? 11'h0 : paddr, pdata};
  int n_mismatch = 0;
  int n_compared = 0;
  int t_prog = -2000;
  bit en_m = 1'b0;
  logic [15:0] seed = 16'h9925;
  logic [3:0] tab [5] = '{4'h4, 4'h1, 4'hC, 4'h2, 4'h8};
  logic [27:0] pq [$];
  logic [27:0] rq [$];
  always #12.5 clk = ~clk;
  serial_eeprom_program_control #(.PROG_CYCLES(PC)) serial_eeprom_program_control_inst (
    .i_core_clk(clk), .i_srst(srst), .i_chip_select(cs), .i_serial_clock_in(sk),
    .i_serial_data_in(di), .i_word_width_select(w16), .o_data_out(dout),
    .o_data_out_en(dout_en), .o_prog_write(pw), .o_prog_all(pall), .o_prog_addr(paddr),
    .o_prog_data(pdata), .o_read_req(rreq), .o_read_addr(raddr), .o_write_enabled(wen),
    .o_busy(busy));
  serial_master_model master (.i_core_clk(clk), .o_chip_select(cs), .o_serial_clock(sk),
    .o_serial_data(di));
  ////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(negedge clk) if (!srst) begin
    if (pw === 1'b1) check(prog_got, pq.size() ? pq.pop_front() : '1);
    if (rreq === 1'b1) check(raddr, rq.size() ? rq.pop_front() : '1);
  end
  task drop;
    master.select(1'b0);
    check(dout_en, 1'b0);
  endtask
  task poll(input logic rdy);
    master.select(1'b1);
    check({dout_en, dout}, {1'b1, rdy});
  endtask
  task automatic run(input [3:0] c, input [10:0] a, input [15:0] d, input int cut);
    logic [31:0] b;
    int n;
    bit idle, go, nen, prog;
    idle = $time - t_prog > PC * 25 && cut == 0;
    go = en_m && idle;
    prog = c == 4'h4 || c == 4'h1 || c == 4'hC || c == 4'h2;
    nen = (idle && c == {`OPC_EXT, `EXT_ENABLE}) || (en_m && !(idle && c == 4'h0));
    if (w16) a[10] = 1'b0;
    else d[15:8] = 8'h0;
    if (c[3:2] == `OPC_EXT) a = w16 ? {1'b0, c[1:0], a[7:0]} : {c[1:0], a[8:0]};
    b = (32'({1'b1, c[3:2]}) << (w16 ? 10 : 11)) | a;
    n = w16 ? 13 : 14;
    if (c == 4'h4 || c == 4'h1) begin
      b = (b << (w16 ? 16 : 8)) | d;
      n += w16 ? 16 : 8;
      if (go) pq.push_back({c == 4'h1, c == 4'h1 ? 11'h0 : a, d});
    end else if (go && prog)
      pq.push_back({c == 4'h2, c == 4'h2 ? 11'h0 : a, w16 ? 16'hFFFF : 16'h00FF});
    if (idle && c[3:2] == `OPC_READ) rq.push_back(a);
    master.select(1'b1);
    master.shift(b >> cut, n + 2 - cut);
    if (go && prog) t_prog = $time;
    repeat (2) @(negedge clk);
    check(wen, en_m);
    drop;
    en_m = nen;
    check(wen, en_m);
  endtask
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    check(wen, 1'b0);
    run(4'h4, 11'h055, 16'h1234, 0);
    run(4'h8, 11'h3C3, 16'h0, 0);
    run(4'h3, 11'h0, 16'h0, 4);
    run(4'h3, 11'h0, 16'h0, 0);
    run(4'h4, 11'h0A5, 16'hBEEF, 0);
    run(4'h4, 11'h0A6, 16'h0001, 0);
    for (int i = 0; i < 10; i++) begin
      w16 = i[0];
      seed = lfsr(lfsr(seed));
      run(tab[i % 5], seed[10:0], lfsr(seed), 0);
      if (i % 5 != 4) begin
        poll(1'b0);
        drop;
        poll(1'b0);
        repeat (PC) @(negedge clk);
        poll(1'b1);
        master.shift(32'h1, 1);
        repeat (2) @(negedge clk);
        check(dout_en, 1'b0);
        drop;
      end
    end
    run(4'h0, 11'h0, 16'h0, 0);
    run(4'h4, 11'h011, 16'h5A5A, 0);
    repeat (60) @(negedge clk);
    check(pq.size() + rq.size(), 0);
    report_and_stop;
  end
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop;
  end
endmodule // testbench
